/* File: adc_bias_tolerance_cfg.sv */
// Register bank: input tolerance, mic bias and full-scale selection.
// Assumes a decoded single-cycle register port from the control interface.
//
// Notes on behaviour
// R1: Channel A tolerance at bits 7-6, read/write, reset zero.
// R2: Channel B tolerance at bits 5-4, same encoding, reset zero.
// R3: Host picks full-supply tolerance only with 10k or 20k impedance.
// R4: Reserved bits read zero; reserved codes must not be written.
// R5: Bias select at bits 6-4, codes 0-6 pick bias source.
// R6: Code 7 releases bias pin and makes it general input two.
// R7: Negative-input and average options derive bias from input pins.
// R8: Full-scale at bits 1-0: 2.75, 2.5, 1.375 V; 3 reserved.
// R9: Host picks full-scale according to minimum analog supply.
// R10: Reference-based bias codes follow the current full-scale choice.
// R11: Bias and full-scale register at 0x3B, reset zero.
// R12: Channel one config zero register at 0x3C, reset zero.
// R13: Tolerance register at 0x3A, reset zero.
// R14: Monitor bit 6 shows sampled pin level in input mode.
// R15: Fields reset on device reset, change only on host writes.
`timescale 1ns/100ps
`default_nettype none
module adc_bias_tolerance_cfg
  import bias_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output var  logic [7:0] reg_rdata,
  output logic            reg_hit,
  input  wire logic       mic_bias_pin_in,
  output logic            mic_bias_pin_oe,
  output logic [2:0]      mic_bias_source,
  output logic [1:0]      converter_full_scale,
  output logic [1:0]      chan_a_common_tolerance,
  output logic [1:0]      chan_b_common_tolerance,
  output logic [7:0]      channel_one_config_zero,
  output logic            general_input_two,
  output logic [7:0]      input_monitor_bits
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Address compare shared by write enables and read select
  function automatic logic addr_is(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return (addr == target);
  endfunction

  // Reserved bits dropped here, so they always read back zero
  function automatic logic [7:0] keep_writable(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    return data & mask;
  endfunction

  // A write replaces the whole byte; anything else holds it
  function automatic logic [7:0] next_value(
    input logic       write,
    input logic [7:0] data,
    input logic [7:0] current
  );
    return write ? data : current;
  endfunction

  // Two-bit code taken from a byte at a given low bit
  function automatic logic [1:0] code_at(
    input logic [7:0] value,
    input int         lsb
  );
    return value[lsb +: 2];
  endfunction

  // Select code that hands the bias pin over to the input path
  function automatic logic releases_pin(
    input logic [2:0] code
  );
    return (code == BIAS_AS_INPUT);
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] tol_reg;
  logic [7:0] tol_next;
  logic [7:0] bias_reg;
  logic [7:0] bias_next;
  logic [7:0] ch1_reg;
  logic [7:0] ch1_next;
  logic       gpi_level;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic       sel_tol;
  logic       sel_bias;
  logic       sel_ch1;
  logic       wr_tol;
  logic       wr_bias;
  logic       wr_ch1;

  assign sel_tol  = addr_is(reg_addr, TOL_ADDR);      // R13
  assign sel_bias = addr_is(reg_addr, BIAS_ADDR);     // R11
  assign sel_ch1  = addr_is(reg_addr, CHANNEL_ONE_CONFIG_ZERO_ADDR); // R12

  // Unmapped addresses decode to nothing, so writes there are lost
  assign wr_tol  = reg_we & sel_tol;
  assign wr_bias = reg_we & sel_bias;
  assign wr_ch1  = reg_we & sel_ch1;

  // ----------------------------------------
  // Write data
  // ----------------------------------------
  logic [7:0] tol_wr;
  logic [7:0] bias_wr;

  // Reserved bits masked off so they can never read back nonzero
  assign tol_wr  = keep_writable(reg_wdata, TOL_WMASK);  // R4
  assign bias_wr = keep_writable(reg_wdata, BIAS_WMASK); // R4

  // Reserved codes are stored as written; the host keeps them out
  assign tol_next  = next_value(wr_tol, tol_wr, tol_reg);    // R1 R2 R15
  assign bias_next = next_value(wr_bias, bias_wr, bias_reg); // R5 R8 R15
  assign ch1_next  = next_value(wr_ch1, reg_wdata, ch1_reg); // R12 R15

  // Each register in its own short process
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tol_reg <= TOL_RESET; // R13
    end else begin
      tol_reg <= tol_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bias_reg <= BIAS_RESET; // R11
    end else begin
      bias_reg <= bias_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1_reg <= CHANNEL_ONE_CONFIG_ZERO_RESET; // R12
    end else begin
      ch1_reg <= ch1_next;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rd_tol;
  logic [7:0] rd_bias;
  logic [7:0] rd_ch1;
  logic [7:0] rd_mux;

  // And-or select; the decodes are exclusive, so no priority needed
  assign rd_tol  = sel_tol  ? tol_reg  : 8'h00;
  assign rd_bias = sel_bias ? bias_reg : 8'h00;
  assign rd_ch1  = sel_ch1  ? ch1_reg  : 8'h00;
  assign rd_mux  = rd_tol | rd_bias | rd_ch1;

  // Unmapped addresses read zero; registered so data comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      reg_rdata <= rd_mux;
    end
  end

  assign reg_hit = sel_tol | sel_bias | sel_ch1;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic [1:0] cha_code;
  logic [1:0] chb_code;
  logic [2:0] source_code;
  logic [1:0] scale_code;

  assign cha_code    = code_at(tol_reg, CHA_TOL_LSB);  // R1
  assign chb_code    = code_at(tol_reg, CHB_TOL_LSB);  // R2
  // Codes 2-4 tap input pins; 0-1 scale with the full-scale choice
  assign source_code = bias_reg[MBIAS_LSB +: 3];       // R5 R7 R10
  assign scale_code  = code_at(bias_reg, FSCALE_LSB);  // R8 R10

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  assign chan_a_common_tolerance = cha_code;
  assign chan_b_common_tolerance = chb_code;
  assign mic_bias_source         = source_code;
  assign converter_full_scale    = scale_code;
  assign channel_one_config_zero = ch1_reg;

  // Driver off only for the input code, so reset leaves the bias driven
  assign mic_bias_pin_oe = ~releases_pin(source_code); // R6

  // ----------------------------------------
  // Pin input monitor
  // ----------------------------------------
  // Two flops, since the pin level is asynchronous to clk
  gpi_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_in (mic_bias_pin_in),
    .level  (gpi_level)
  );

  // Gated by the select code, but the two sync flops still pass a driven level for two cycles after code 7
  assign general_input_two = releases_pin(source_code) & gpi_level; // R6 R14
  assign input_monitor_bits = {1'b0, general_input_two, 6'h00}; // R14
endmodule
`default_nettype wire

/* File: bias_cfg_pkg.sv */
// Package for the bias and common-mode tolerance register bank.
// Assumes an 8-bit register port from the control interface decoder.
package bias_cfg_pkg;
  localparam logic [7:0] TOL_ADDR        = 8'h3a;
  localparam logic [7:0] BIAS_ADDR       = 8'h3b;
  localparam logic [7:0] CHANNEL_ONE_CONFIG_ZERO_ADDR   = 8'h3c;
  localparam logic [7:0] TOL_RESET       = 8'h00;
  localparam logic [7:0] BIAS_RESET      = 8'h00;
  localparam logic [7:0] CHANNEL_ONE_CONFIG_ZERO_RESET  = 8'h00;
  localparam logic [7:0] TOL_WMASK       = 8'hf0;
  localparam logic [7:0] BIAS_WMASK      = 8'h73;
  localparam int         CHA_TOL_LSB     = 6;
  localparam int         CHB_TOL_LSB     = 4;
  localparam int         MBIAS_LSB       = 4;
  localparam int         FSCALE_LSB      = 0;
  localparam int         MON_GENERAL_INPUT_TWO_BIT    = 6;
  localparam logic [1:0] TOL_RESERVED    = 2'h3;
  localparam logic [1:0] FSCALE_RESERVED = 2'h3;

  typedef enum logic [2:0] {
    BIAS_VREF     = 3'b000,
    BIAS_VREF_X   = 3'b001,
    BIAS_IN1_NEG  = 3'b010,
    BIAS_IN2_NEG  = 3'b011,
    BIAS_AVG_NEG  = 3'b100,
    BIAS_INT_CM   = 3'b101,
    BIAS_SUPPLY   = 3'b110,
    BIAS_AS_INPUT = 3'b111
  } mic_bias_select_t;
endpackage

/* File: gpi_sync.sv */
// Two-stage synchroniser for the bias pin when it serves as an input.
// Assumes the pin level is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module gpi_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output var  logic level
);
  logic meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      level    <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      level    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: mic_pin_model.sv */
// Outside party on the bias pin.
// Assumes ext is a random level from the bench.
`timescale 1ns/100ps
`default_nettype none
module mic_pin_model (
  input  wire logic clk,
  input  wire logic oe,
  input  wire logic ext,
  output var  logic pin
);
  // Driven pin reads inverted ext, released pin reads ext, both registered one clock late
  always_ff @(posedge clk) pin <= oe ? ~ext : ext;
endmodule
`default_nettype wire

/* File: adc_bias_tolerance_cfg_asserts.sv */
// Port checker for the bias and tolerance bank.
// Assumes one clock, rst async high.
`timescale 1ns/100ps
`default_nettype none
module adc_bias_tolerance_cfg_asserts (
  input wire logic       clk, rst, reg_we, reg_re, mic_bias_pin_in,
  input wire logic       mic_bias_pin_oe, general_input_two,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, input_monitor_bits,
  input wire logic [2:0] mic_bias_source,
  input wire logic [1:0] converter_full_scale,
  input wire logic [1:0] chan_a_common_tolerance, chan_b_common_tolerance
);
  wire logic [3:0] tol_f = {chan_a_common_tolerance, chan_b_common_tolerance};
  wire logic [4:0] bias_f = {mic_bias_source, converter_full_scale};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_tol_write: assert property (reg_we && reg_addr == 8'h3a |=>
    tol_f == $past(reg_wdata[7:4])) else $error("tolerance not written");
  a_bias_write: assert property (reg_we && reg_addr == 8'h3b |=>
    bias_f == {$past(reg_wdata[6:4]), $past(reg_wdata[1:0])})
    else $error("bias not written");
  a_fields_hold: assert property (!reg_we |=>
    $stable({tol_f, bias_f})) else $error("field moved without write");
  a_pin_release: assert property (
    mic_bias_pin_oe == (mic_bias_source != 3'h7)) else $error("pin enable");
  a_monitor_bit: assert property (
    input_monitor_bits == {1'b0, general_input_two, 6'h00})
    else $error("monitor bits");
  a_gpi_follow: assert property ((mic_bias_source == 3'h7) [*3] |->
    general_input_two == $past(mic_bias_pin_in, 2)) else $error("gpi level");
  a_read_bias: assert property (reg_re && reg_addr == 8'h3b |=>
    reg_rdata == {1'b0, $past(bias_f[4:2]), 2'b00, $past(bias_f[1:0])})
    else $error("bias readback");
  a_read_tol: assert property (reg_re && reg_addr == 8'h3a |=>
    reg_rdata == {$past(tol_f), 4'h0}) else $error("tolerance readback");
endmodule
bind adc_bias_tolerance_cfg adc_bias_tolerance_cfg_asserts chk_i (.*);
`default_nettype wire

/* File: tb.sv */
// Bench: random register traffic, readback queue, mid-run reset.
// Assumes the pin model and bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk, rst, reg_we, reg_re, ext, pin, oe, re_d;
  logic [7:0] reg_addr, reg_wdata, rdata, a, d;
  logic [7:0] m [4];
  logic [7:0] q [$];
  logic        gi2, p1, p2;
  logic [1:0]  ta, tbn, fs;
  logic [2:0]  src;
  logic [7:0]  c1, mon;
  logic [17:0] e;
  logic [17:0] fq [$];
  int         bad_count, compares, cyc;
  adc_bias_tolerance_cfg adc_bias_tolerance_cfg_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(rdata), .reg_hit(), .mic_bias_pin_in(pin),
    .mic_bias_pin_oe(oe), .mic_bias_source(src), .converter_full_scale(fs),
    .chan_a_common_tolerance(ta), .chan_b_common_tolerance(tbn),
    .channel_one_config_zero(c1), .general_input_two(gi2),
    .input_monitor_bits(mon));
  mic_pin_model mic_pin_model_i (.clk(clk), .oe(oe), .ext(ext), .pin(pin));
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Unmapped 0x39/0x3d share slot 1, never written, so they expect zero
  task automatic acc(input logic [7:0] ad, dt, input logic w, r);
    {reg_addr, reg_wdata, reg_we, reg_re} <= {ad, dt, w, r};
    if (r) q.push_back(m[ad[1:0]]);
    if (w && ad inside {8'h3a, 8'h3b, 8'h3c}) m[ad[1:0]] = dt;
    // Fields as they stand one edge later, with the driver enable last
    if (r) fq.push_back({m[2][7:4], m[3][6:4], m[3][1:0], m[0],
                         m[3][6:4] != 3'h7});
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (re_d) begin
      chk(rdata, q.pop_front());
      e = fq.pop_front();
      chk({ta, tbn, src, fs, c1, oe}, e);
      chk({gi2, mon}, {~e[0] & p2, 1'b0, ~e[0] & p2, 6'h00});
    end
    p1 <= pin;
    p2 <= p1;
    re_d <= reg_re;
    ext <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_we, reg_re, ext, re_d, cyc} = '0;
    rst = 1'b1;
    m = '{default: 8'h00};
    void'($urandom(32'hc063ae06));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    acc(8'h3b, 8'h70, 1'b1, 1'b0);
    for (int i = 0; i < 70; i++) begin
      a = 8'h39 + 8'($urandom % 5);
      d = 8'($urandom);
      // Host never writes reserved codes or reserved bits
      if (a == 8'h3a) d = {d[7] & ~d[6], d[6], d[5] & ~d[4], d[4], 4'h0};
      if (a == 8'h3b) d = {1'b0, d[6:4], 2'b00, d[1] & ~d[0], d[0]};
      acc(a, d, 1'b1, 1'b1);
      acc(a, 8'h00, 1'b0, 1'b1);
      repeat (i % 4) acc(a, d, 1'b0, 1'b0);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    m = '{default: 8'h00};
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) acc(8'h39 + 8'(k), 8'h00, 1'b0, 1'b1);
    repeat (3) acc(8'h39, 8'h00, 1'b0, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
